// ---- elr_event_log.sv ----
// Event log with recall displays for the lift controller
`timescale 1ns/1ps
`include "elr_map.svh"
module elr_event_log import elr_pkg::*; #(
	parameter int DEPTH = `ELR_DEPTH,
	parameter int POS_W = `ELR_POS_W,
	parameter logic [31:0] SHOW_CYCLES = 32'(`ELR_SHOW_CYCLES),
	parameter logic [31:0] BLEEP_CYCLES = 32'(`ELR_BLEEP_CYCLES),
	parameter logic [31:0] EXIT_CYCLES = 32'(`ELR_EXIT_CYCLES),
	parameter logic [31:0] IDLE_CYCLES = 32'(`ELR_IDLE_CYCLES),
	parameter logic [39:0] DAY_CYCLES = 40'(`ELR_DAY_CYCLES)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Event source, same clock domain
	input wire logic event_strobe,
	input wire elr_sym_t event_code,
	input wire logic [POS_W-1:0] lift_position,
	// Service pushbuttons, raw pins, active high
	input wire logic recall_step_button,
	input wire logic occurrence_count_button,
	input wire logic day_age_button,
	input wire logic engineer_visit_button,
	input wire logic recall_exit_button,
	// Event code display and bleep
	output elr_sym_t event_disp_sym,
	output logic event_disp_dp,
	output logic bleep,
	// Position display and recall mode flag
	output elr_pdmode_e pos_disp_mode,
	output logic [7:0] pos_disp_value,
	output logic pos_disp_dp,
	output logic recall_active
);
	localparam int CW = `ELR_CNT_W;
	localparam int AW = `ELR_AGE_W;
	localparam int IW = $clog2(DEPTH + 1);

	// ----------------------------------------
	// Ring arithmetic
	// ----------------------------------------
	function automatic logic [IW-1:0] ring_inc(input logic [IW-1:0] p);
		ring_inc = (p == IW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [IW-1:0] ring_back(input logic [IW-1:0] p, input logic [IW-1:0] off);
		ring_back = (p >= off) ? p - off : IW'(p + IW'(DEPTH) - off);
	endfunction

	// ----------------------------------------
	// Buttons and timers
	// ----------------------------------------
	logic step_press, cnt_press, age_press, eng_press, exit_press;
	logic show_load, bleep_load, exit_load, idle_load, day_load;
	logic show_busy, bleep_busy, exit_busy, idle_busy, day_busy;
	logic show_done, bleep_done, exit_done, idle_done, day_done;

	elr_btn_sync u_step (.clk(clk), .nrst(nrst), .pin(recall_step_button), .press(step_press));
	elr_btn_sync u_cnt (.clk(clk), .nrst(nrst), .pin(occurrence_count_button), .press(cnt_press));
	elr_btn_sync u_age (.clk(clk), .nrst(nrst), .pin(day_age_button), .press(age_press));
	elr_btn_sync u_eng (.clk(clk), .nrst(nrst), .pin(engineer_visit_button), .press(eng_press));
	elr_btn_sync u_exit (.clk(clk), .nrst(nrst), .pin(recall_exit_button), .press(exit_press));

	elr_timer #(.W(32)) u_show (.clk(clk), .nrst(nrst), .load(show_load), .period(SHOW_CYCLES),
		.busy(show_busy), .done(show_done));
	elr_timer #(.W(32)) u_bleep (.clk(clk), .nrst(nrst), .load(bleep_load), .period(BLEEP_CYCLES),
		.busy(bleep_busy), .done(bleep_done));
	elr_timer #(.W(32)) u_exit_t (.clk(clk), .nrst(nrst), .load(exit_load), .period(EXIT_CYCLES),
		.busy(exit_busy), .done(exit_done));
	elr_timer #(.W(32)) u_idle (.clk(clk), .nrst(nrst), .load(idle_load), .period(IDLE_CYCLES),
		.busy(idle_busy), .done(idle_done));
	elr_timer #(.W(40)) u_day (.clk(clk), .nrst(nrst), .load(day_load), .period(DAY_CYCLES),
		.busy(day_busy), .done(day_done));

	// ----------------------------------------
	// State
	// ----------------------------------------
	elr_sym_t code_reg [DEPTH];
	elr_sym_t code_next [DEPTH];
	logic [POS_W-1:0] pos_reg [DEPTH];
	logic [POS_W-1:0] pos_next [DEPTH];
	logic [CW-1:0] cnt_reg [DEPTH];
	logic [CW-1:0] cnt_next [DEPTH];
	logic [AW-1:0] age_reg [DEPTH];
	logic [AW-1:0] age_next [DEPTH];
	logic [IW-1:0] wr_ptr_reg, wr_ptr_next, fill_reg, fill_next, offset_reg, offset_next;
	logic [IW-1:0] sel, step_off;
	elr_state_e state_reg, state_next;
	elr_pdmode_e pdmode_reg, pdmode_next, pos_disp_mode_reg, pos_disp_mode_next;
	elr_sym_t newcode_reg, newcode_next, event_disp_sym_reg, event_disp_sym_next, new_code;
	logic newdp_reg, newdp_next, event_disp_dp_reg, event_disp_dp_next;
	logic bleep_reg, pos_disp_dp_reg, pos_disp_dp_next, recall_active_reg;
	logic [7:0] pos_disp_value_reg, pos_disp_value_next;
	logic new_valid, eng_take, merge, any_press, sel_valid;

	// Queue, recall sequencer and display selection
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			code_next[i] = code_reg[i];
			pos_next[i] = pos_reg[i];
			cnt_next[i] = cnt_reg[i];
			age_next[i] = age_reg[i];
		end
		wr_ptr_next = wr_ptr_reg;
		fill_next = fill_reg;
		offset_next = offset_reg;
		state_next = state_reg;
		pdmode_next = pdmode_reg;
		newcode_next = newcode_reg;
		newdp_next = newdp_reg;
		exit_load = 1'b0;
		day_load = ~day_busy;

		// Day ageing of every entry, held at full scale
		if (day_done) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (age_reg[i] != '1) begin // RULE18
					age_next[i] = age_reg[i] + 1'b1; // RULE4
				end
			end
		end

		// Engineer mark only when the show timer is idle, in recall too; a fault in the same cycle wins
		eng_take = eng_press & ~event_strobe & ~show_busy; // RULE17
		new_valid = event_strobe | eng_take; // RULE6
		new_code = event_strobe ? event_code : `ELR_SYM_ENGINEER; // RULE17
		merge = new_valid && (fill_reg != '0) && (code_reg[wr_ptr_reg] == new_code)
			&& (pos_reg[wr_ptr_reg] == lift_position); // RULE3

		if (merge) begin
			if (cnt_reg[wr_ptr_reg] != '1) begin // RULE18
				cnt_next[wr_ptr_reg] = cnt_reg[wr_ptr_reg] + 1'b1; // RULE3
			end
		end else if (new_valid) begin
			// Oldest slot is simply overwritten once the ring is full
			wr_ptr_next = ring_inc(wr_ptr_reg); // RULE5
			code_next[wr_ptr_next] = new_code; // RULE2
			pos_next[wr_ptr_next] = lift_position; // RULE2
			cnt_next[wr_ptr_next] = CW'(1);
			age_next[wr_ptr_next] = '0;
			if (fill_reg != IW'(DEPTH)) begin
				fill_next = fill_reg + 1'b1; // RULE5
			end
		end
		if (new_valid) begin
			newcode_next = new_code; // RULE1
			newdp_next = merge && (new_code == `ELR_SYM_CALLXFER); // RULE16
		end
		show_load = new_valid; // RULE1
		bleep_load = new_valid; // RULE1

		// Recall sequencer
		any_press = step_press | cnt_press | age_press | eng_press | exit_press;
		idle_load = any_press; // RULE13
		sel_valid = (offset_reg < fill_reg);
		step_off = (offset_reg >= fill_reg) ? '0 : offset_reg + 1'b1; // RULE11
		case (state_reg)
			ELR_IDLE: begin
				if (step_press) begin
					state_next = ELR_RECALL;
					offset_next = '0; // RULE7
					pdmode_next = (fill_reg == '0) ? ELR_PD_HYPHEN : ELR_PD_STORED; // RULE7
				end
			end
			ELR_RECALL: begin
				if (exit_press) begin
					state_next = ELR_LEAVING;
					pdmode_next = ELR_PD_HYPHEN; // RULE12
					exit_load = 1'b1; // RULE12
				end else if (idle_done) begin
					state_next = ELR_IDLE; // RULE13
					pdmode_next = ELR_PD_PRESENT;
				end else if (step_press) begin
					offset_next = step_off; // RULE10
					pdmode_next = (step_off == fill_reg) ? ELR_PD_HYPHEN : ELR_PD_STORED; // RULE11
				end else if (cnt_press && sel_valid) begin
					pdmode_next = ELR_PD_COUNT; // RULE8
				end else if (age_press && sel_valid) begin
					pdmode_next = ELR_PD_AGE; // RULE9
				end
			end
			ELR_LEAVING: begin
				if (exit_done) begin
					state_next = ELR_IDLE; // RULE12
					pdmode_next = ELR_PD_PRESENT;
				end
			end
			default: begin
				state_next = ELR_IDLE;
				pdmode_next = ELR_PD_PRESENT;
			end
		endcase

		// Display contents from present state; outputs lag state by one cycle
		sel = ring_back(wr_ptr_reg, offset_reg);
		event_disp_dp_next = 1'b0;
		pos_disp_mode_next = pdmode_reg;
		if (state_reg == ELR_RECALL) begin
			event_disp_sym_next = sel_valid ? code_reg[sel] : `ELR_SYM_HYPHEN; // RULE7
		end else if (state_reg == ELR_LEAVING) begin
			event_disp_sym_next = `ELR_SYM_HYPHEN; // RULE12
		end else begin
			event_disp_sym_next = show_busy ? newcode_reg : `ELR_SYM_BLANK; // RULE1 RULE14 RULE15
			event_disp_dp_next = show_busy & newdp_reg; // RULE16
			pos_disp_mode_next = (show_busy && newcode_reg == `ELR_SYM_ENGINEER) ? ELR_PD_BARS
				: ELR_PD_PRESENT; // RULE17
		end
		case (pos_disp_mode_next)
			ELR_PD_PRESENT: pos_disp_value_next = 8'(lift_position);
			ELR_PD_STORED: pos_disp_value_next = 8'(pos_reg[sel]); // RULE7
			ELR_PD_COUNT: pos_disp_value_next = 8'(cnt_reg[sel]); // RULE8
			ELR_PD_AGE: pos_disp_value_next = 8'(age_reg[sel]); // RULE9
			default: pos_disp_value_next = 8'h00;
		endcase
		pos_disp_dp_next = (pos_disp_mode_next == ELR_PD_STORED); // RULE7
	end

	// Register everything; reset clears the queue contents as well as the fill count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				code_reg[i] <= `ELR_SYM_BLANK;
				pos_reg[i] <= '0;
				cnt_reg[i] <= '0;
				age_reg[i] <= '0;
			end
			wr_ptr_reg <= IW'(DEPTH - 1);
			fill_reg <= '0;
			offset_reg <= '0;
			state_reg <= ELR_IDLE;
			pdmode_reg <= ELR_PD_PRESENT;
			newcode_reg <= `ELR_SYM_BLANK;
			newdp_reg <= 1'b0;
			event_disp_sym_reg <= `ELR_SYM_BLANK;
			event_disp_dp_reg <= 1'b0;
			bleep_reg <= 1'b0;
			pos_disp_mode_reg <= ELR_PD_PRESENT;
			pos_disp_value_reg <= 8'h00;
			pos_disp_dp_reg <= 1'b0;
			recall_active_reg <= 1'b0;
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				code_reg[i] <= code_next[i];
				pos_reg[i] <= pos_next[i];
				cnt_reg[i] <= cnt_next[i];
				age_reg[i] <= age_next[i];
			end
			wr_ptr_reg <= wr_ptr_next;
			fill_reg <= fill_next;
			offset_reg <= offset_next;
			state_reg <= state_next;
			pdmode_reg <= pdmode_next;
			newcode_reg <= newcode_next;
			newdp_reg <= newdp_next;
			event_disp_sym_reg <= event_disp_sym_next;
			event_disp_dp_reg <= event_disp_dp_next;
			bleep_reg <= bleep_busy; // RULE1
			pos_disp_mode_reg <= pos_disp_mode_next;
			pos_disp_value_reg <= pos_disp_value_next;
			pos_disp_dp_reg <= pos_disp_dp_next;
			recall_active_reg <= (state_reg != ELR_IDLE);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign event_disp_sym = event_disp_sym_reg;
	assign event_disp_dp = event_disp_dp_reg;
	assign bleep = bleep_reg;
	assign pos_disp_mode = pos_disp_mode_reg;
	assign pos_disp_value = pos_disp_value_reg;
	assign pos_disp_dp = pos_disp_dp_reg;
	assign recall_active = recall_active_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_recall_enter;
		state_reg == ELR_IDLE && step_press && fill_reg != '0;
	endsequence

	sequence s_exit_req;
		state_reg == ELR_RECALL && exit_press;
	endsequence

	sequence s_plain_recall;
		state_reg == ELR_RECALL && !exit_press && !idle_done && !step_press;
	endsequence

	chk_show_new_code: assert property ( // RULE1
		event_strobe && state_reg == ELR_IDLE && !step_press
		|-> ##2 bleep && event_disp_sym == $past(event_code, 2))
		else $error("new event not shown with bleep");

	chk_write_entry: assert property ( // RULE2
		new_valid && !merge
		|=> code_reg[wr_ptr_reg] == $past(new_code) && pos_reg[wr_ptr_reg] == $past(lift_position)
			&& cnt_reg[wr_ptr_reg] == CW'(1))
		else $error("new entry not written");

	chk_merge_count: assert property ( // RULE3
		merge && cnt_reg[wr_ptr_reg] != '1
		|=> wr_ptr_reg == $past(wr_ptr_reg) && fill_reg == $past(fill_reg)
			&& cnt_reg[wr_ptr_reg] == $past(cnt_reg[wr_ptr_reg]) + 1'b1)
		else $error("repeat entry not merged");

	chk_age_step: assert property ( // RULE4
		day_done && !new_valid && age_reg[0] != '1 |=> age_reg[0] == $past(age_reg[0]) + 1'b1)
		else $error("day age not stepped");

	chk_fill_full: assert property ( // RULE5
		fill_reg == IW'(DEPTH) && new_valid && !merge |=> fill_reg == IW'(DEPTH)
		&& wr_ptr_reg == ring_inc($past(wr_ptr_reg)))
		else $error("full queue did not drop oldest");

	chk_log_in_recall: assert property ( // RULE6
		state_reg != ELR_IDLE && event_strobe && !merge
		|=> wr_ptr_reg == ring_inc($past(wr_ptr_reg)) && code_reg[wr_ptr_reg] == $past(event_code)
			&& fill_reg == (($past(fill_reg) == IW'(DEPTH)) ? IW'(DEPTH) : IW'($past(fill_reg) + 1'b1)))
		else $error("event lost during recall");

	chk_first_step: assert property ( // RULE7
		s_recall_enter |-> ##2 pos_disp_mode == ELR_PD_STORED && pos_disp_dp
			&& event_disp_sym == code_reg[wr_ptr_reg])
		else $error("first step shows wrong entry");

	chk_count_show: assert property ( // RULE8
		s_plain_recall and cnt_press && sel_valid |-> ##2 pos_disp_mode == ELR_PD_COUNT && !pos_disp_dp)
		else $error("count not shown");

	chk_age_show: assert property ( // RULE9
		s_plain_recall and age_press && !cnt_press && sel_valid |-> ##2 pos_disp_mode == ELR_PD_AGE)
		else $error("age not shown");

	chk_step_wrap: assert property ( // RULE11
		state_reg == ELR_RECALL && step_press && !exit_press && !idle_done && offset_reg == fill_reg
		|=> offset_reg == '0)
		else $error("step after hyphen did not wrap");

	chk_exit_hyphen: assert property ( // RULE12
		s_exit_req |=> state_reg == ELR_LEAVING ##1 pos_disp_mode == ELR_PD_HYPHEN
			&& event_disp_sym == `ELR_SYM_HYPHEN)
		else $error("exit did not show hyphen");

	chk_idle_timeout: assert property ( // RULE13
		state_reg == ELR_RECALL && idle_done && !exit_press |=> state_reg == ELR_IDLE ##1 !recall_active)
		else $error("recall did not time out");

	chk_engineer_mark: assert property ( // RULE17
		eng_take |=> newcode_reg == `ELR_SYM_ENGINEER && show_busy)
		else $error("engineer mark not logged");
endmodule

// ---- elr_map.svh ----
// Event log recall constants: symbol codes, queue sizes and timing figures
// Function
// RULE1 - New event code is shown about five seconds with a short warning bleep.
// RULE2 - Each recorded event stores its code with the lift position at that moment.
// RULE3 - Same code and position as newest entry bumps its count instead of adding.
// RULE4 - Each entry has a day-age counter stepped roughly every twenty-four hours.
// RULE5 - Queue holds twenty entries; adding when full drops the oldest one.
// RULE6 - Recall never blocks logging; events during recall still enter the queue.
// RULE7 - First step press shows newest code and its stored position with point lit.
// RULE8 - Count press in recall shows the selected entry's occurrence count.
// RULE9 - Age press in recall shows the selected entry's age in days, zero is today.
// RULE10 - Further step presses select the next older entry, code and stored position.
// RULE11 - After the oldest entry a hyphen shows, then stepping wraps to newest.
// RULE12 - Exit press shows a hyphen, then after two seconds the present position.
// RULE13 - Recall ends by itself after twenty seconds without any button press.
// RULE14 - Codes zero to nine name the ten basic lift faults in fixed order.
// RULE15 - Letter codes name overload, engineer, shutdown, nudging and other faults.
// RULE16 - Code C first means calls handed over, repeated means calls cancelled.
// RULE17 - Engineer press with no code shown shows three bars, bleeps, logs code B.
// RULE18 - Occurrence and day-age counters stop at their maximum instead of wrapping.
`ifndef ELR_MAP_SVH
`define ELR_MAP_SVH

// ----------------------------------------
// Queue geometry
// ----------------------------------------
`define ELR_DEPTH 20
`define ELR_CNT_W 8
`define ELR_AGE_W 8
`define ELR_POS_W 8

// ----------------------------------------
// Display symbols (digits 0..9 are their own value)
// ----------------------------------------
`define ELR_SYM_OVERLOAD 5'h0a
`define ELR_SYM_ENGINEER 5'h0b
`define ELR_SYM_CALLXFER 5'h0c
`define ELR_SYM_SHUTDOWN 5'h0e
`define ELR_SYM_NUDGE 5'h0f
`define ELR_SYM_MEMFAIL 5'h10
`define ELR_SYM_STACK 5'h11
`define ELR_SYM_LANDFEED 5'h12
`define ELR_SYM_PROGERR 5'h13
`define ELR_SYM_EDGEOVT 5'h14
`define ELR_SYM_CARFEED 5'h15
`define ELR_SYM_USER 5'h16
`define ELR_SYM_STARTFAIL 5'h17
`define ELR_SYM_HYPHEN 5'h1e
`define ELR_SYM_BLANK 5'h1f

// ----------------------------------------
// Timing
// ----------------------------------------
`define ELR_CLK_HZ 10000000
`define ELR_SHOW_TIME_S 5
`define ELR_BLEEP_TIME_MS 100
`define ELR_EXIT_TIME_S 2
`define ELR_IDLE_TIME_S 20
`define ELR_DAY_TIME_H 24
`define ELR_SHOW_CYCLES (`ELR_SHOW_TIME_S * `ELR_CLK_HZ)
`define ELR_BLEEP_CYCLES (`ELR_BLEEP_TIME_MS * (`ELR_CLK_HZ / 1000))
`define ELR_EXIT_CYCLES (`ELR_EXIT_TIME_S * `ELR_CLK_HZ)
`define ELR_IDLE_CYCLES (`ELR_IDLE_TIME_S * `ELR_CLK_HZ)
`define ELR_DAY_CYCLES (64'd3600 * `ELR_DAY_TIME_H * `ELR_CLK_HZ)

`endif

// ---- elr_pkg.sv ----
// Event log recall types
package elr_pkg;
	typedef enum logic [1:0] {ELR_IDLE, ELR_RECALL, ELR_LEAVING} elr_state_e;
	typedef enum logic [2:0] {ELR_PD_PRESENT, ELR_PD_STORED, ELR_PD_COUNT, ELR_PD_AGE,
		ELR_PD_HYPHEN, ELR_PD_BARS} elr_pdmode_e;
	typedef logic [4:0] elr_sym_t;
endpackage

// ---- elr_btn_sync.sv ----
// Pushbutton synchroniser with press detector
`timescale 1ns/1ps
module elr_btn_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Raw pin, active high
	input wire logic pin,
	// One-cycle press pulse
	output logic press
);
	logic s1_reg, s2_reg, s3_reg, level_reg, press_reg;
	logic level_next, press_next;

	// Level moves only when the last two stages agree
	always_comb begin
		level_next = level_reg;
		if (s2_reg == s3_reg) begin
			level_next = s2_reg;
		end
		press_next = level_next & ~level_reg;
	end

	// Three-stage chain
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
			press_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
			press_reg <= press_next;
		end
	end

	assign press = press_reg;
endmodule

// ---- elr_timer.sv ----
// Retriggerable down counter with expiry pulse
`timescale 1ns/1ps
module elr_timer #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Load request and period
	input wire logic load,
	input wire logic [W-1:0] period,
	// Status
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_reg, cnt_next;
	logic done_reg, done_next;

	// Reload wins over expiry so a retrigger never fires early
	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (load) begin
			cnt_next = period;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
			done_next = (cnt_reg == {{(W-1){1'b0}}, 1'b1});
		end
	end

	// Count state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign busy = (cnt_reg != '0);
	assign done = done_reg;
endmodule

// ---- elr_svc_panel.sv ----
// Service panel model: timed pushbutton presses on the five raw pins
`timescale 1ns/1ps
module elr_svc_panel (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// One-cycle press request, one bit per button
	input wire logic [4:0] push,
	// Raw button pins: step, count, age, engineer, exit
	output logic [4:0] pins
);
	logic [4:0] held_reg;
	logic [3:0] hold_reg;

	// ----------------------------------------
	// Press timing
	// ----------------------------------------
	// Hold for eight cycles so the three-stage synchroniser surely agrees
	always_ff @(posedge clk) begin
		if (!nrst) begin
			held_reg <= 5'h00;
			hold_reg <= 4'h0;
		end else if (push != 5'h00) begin
			held_reg <= push;
			hold_reg <= 4'h8;
		end else if (hold_reg != 4'h0) begin
			hold_reg <= hold_reg - 4'h1;
		end
	end

	// Released buttons read low, as the pins have pull-downs
	assign pins = (hold_reg != 4'h0) ? held_reg : 5'h00;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the event log with recall displays
`timescale 1ns/1ps
`include "elr_map.svh"
module tb_top import elr_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int SHOW = 50;
	logic clk = 1'b0;
	logic nrst;
	logic event_strobe;
	elr_sym_t event_code;
	logic [7:0] lift_position;
	logic [4:0] push;
	logic [4:0] pins;
	elr_sym_t event_disp_sym;
	logic event_disp_dp;
	logic bleep;
	elr_pdmode_e pos_disp_mode;
	logic [7:0] pos_disp_value;
	logic pos_disp_dp;
	logic recall_active;
	int bleep_cnt = 0;
	int bleep_mark;
	logic [7:0] p;
	int error_cnt;
	int compares;
	elr_sym_t q_code[$];
	logic [7:0] q_pos[$];
	logic [7:0] q_cnt[$];

	// Short counts keep the run brief
	elr_event_log #(.SHOW_CYCLES(32'(SHOW)), .BLEEP_CYCLES(32'd5), .EXIT_CYCLES(32'd20),
		.IDLE_CYCLES(32'd200), .DAY_CYCLES(40'd100)) i_elr_event_log (
		.clk(clk), .nrst(nrst), .event_strobe(event_strobe), .event_code(event_code),
		.lift_position(lift_position), .recall_step_button(pins[0]), .occurrence_count_button(pins[1]),
		.day_age_button(pins[2]), .engineer_visit_button(pins[3]), .recall_exit_button(pins[4]),
		.event_disp_sym(event_disp_sym), .event_disp_dp(event_disp_dp), .bleep(bleep),
		.pos_disp_mode(pos_disp_mode), .pos_disp_value(pos_disp_value), .pos_disp_dp(pos_disp_dp),
		.recall_active(recall_active));
	elr_svc_panel i_elr_svc_panel (.clk(clk), .nrst(nrst), .push(push), .pins(pins));

	// Clock and bleep catcher, since the bleep is shorter than a press
	always #50 clk = ~clk;
	always @(posedge clk) if (bleep === 1'b1) bleep_cnt <= bleep_cnt + 1;

	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic chk_sym(input elr_sym_t got, input elr_sym_t exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: symbol %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(input elr_pdmode_e got, input elr_pdmode_e exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: mode %0d, expected %0d", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Queue model and drivers
	// ----------------------------------------
	function automatic logic is_merge(input elr_sym_t c, input logic [7:0] pp);
		return q_code.size() != 0 && q_code[0] == c && q_pos[0] == pp;
	endfunction
	// Newest entry at the front; counts stop at 255
	task automatic add_entry(input elr_sym_t c, input logic [7:0] pp);
		if (is_merge(c, pp)) begin
			if (q_cnt[0] != 8'hff) q_cnt[0] = q_cnt[0] + 8'h01;
		end else begin
			q_code.push_front(c);
			q_pos.push_front(pp);
			q_cnt.push_front(8'h01);
			if (q_code.size() > 20) begin
				void'(q_code.pop_back());
				void'(q_pos.pop_back());
				void'(q_cnt.pop_back());
			end
		end
	endtask
	task automatic log_ev(input elr_sym_t c, input logic [7:0] pp, input logic show);
		@(posedge clk);
		event_strobe <= 1'b1;
		event_code <= c;
		lift_position <= pp;
		@(posedge clk);
		event_strobe <= 1'b0;
		add_entry(c, pp);
		repeat (2) @(posedge clk);
		#1;
		chk_bit(bleep, 1'b1);
		if (show) chk_sym(event_disp_sym, c);
	endtask
	task automatic press(input int b);
		@(posedge clk);
		push <= 5'(1 << b);
		@(posedge clk);
		push <= 5'h00;
		repeat (18) @(posedge clk);
		#1;
	endtask
	task automatic wait_drop(input int lim);
		int n;
		n = 0;
		while (recall_active === 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		#1;
		if (recall_active !== 1'b0) begin
			error_cnt++;
			$display("wrong value at %0t: recall mode did not end", $time);
			finish_test();
		end
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		$display("wrong value at %0t: run did not finish in time", $time);
		finish_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		event_strobe = 1'b0;
		event_code = 5'h00;
		lift_position = 8'h00;
		push = 5'h00;
		error_cnt = 0;
		compares = 0;
		void'($urandom(32'ha5d3));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk_sym(event_disp_sym, `ELR_SYM_BLANK);
		chk_mode(pos_disp_mode, ELR_PD_PRESENT);
		// Every code once, more than the queue holds
		for (int k = 0; k < 24; k++) begin
			if (k != 13) log_ev(5'(k), 8'($urandom), 1'b1);
		end
		repeat (SHOW + 5) @(posedge clk);
		#1;
		chk_sym(event_disp_sym, `ELR_SYM_BLANK);
		chk_bit(bleep, 1'b0);
		// Repeated call transfer merges and saturates
		p = 8'($urandom);
		log_ev(`ELR_SYM_CALLXFER, p, 1'b1);
		chk_bit(event_disp_dp, 1'b0);
		log_ev(`ELR_SYM_CALLXFER, p, 1'b1);
		chk_bit(event_disp_dp, 1'b1);
		repeat (300) log_ev(`ELR_SYM_CALLXFER, p, 1'b1);
		repeat (SHOW + 5) @(posedge clk);
		bleep_mark = bleep_cnt;
		lift_position <= 8'($urandom);
		press(3);
		add_entry(`ELR_SYM_ENGINEER, lift_position);
		chk_mode(pos_disp_mode, ELR_PD_BARS);
		chk_bit(bleep_cnt != bleep_mark, 1'b1);
		// Step through the whole queue
		for (int i = 0; i < 20; i++) begin
			press(0);
			chk_sym(event_disp_sym, q_code[i]);
			chk_byte(pos_disp_value, q_pos[i]);
			chk_bit(pos_disp_dp, 1'b1);
			if (i < 2) begin
				press(1);
				chk_mode(pos_disp_mode, ELR_PD_COUNT);
				chk_byte(pos_disp_value, q_cnt[i]);
				press(2);
				chk_mode(pos_disp_mode, ELR_PD_AGE);
				// Repeated C entry is over a thousand cycles old, so ten day ticks at least
				if (i == 0) chk_bit(pos_disp_value <= 8'h02, 1'b1);
				else chk_bit(pos_disp_value >= 8'h0a, 1'b1);
			end
		end
		press(0);
		chk_sym(event_disp_sym, `ELR_SYM_HYPHEN);
		press(0);
		chk_sym(event_disp_sym, q_code[0]);
		// Logging carries on during recall
		log_ev(5'h05, 8'($urandom), 1'b0);
		press(4);
		chk_mode(pos_disp_mode, ELR_PD_HYPHEN);
		chk_bit(recall_active, 1'b1);
		wait_drop(40);
		chk_mode(pos_disp_mode, ELR_PD_PRESENT);
		chk_byte(pos_disp_value, lift_position);
		press(0);
		chk_sym(event_disp_sym, 5'h05);
		chk_byte(pos_disp_value, q_pos[0]);
		// Idle timeout
		repeat (150) @(posedge clk);
		#1;
		chk_bit(recall_active, 1'b1);
		wait_drop(100);
		finish_test();
	end
endmodule
